// File: asof_framer.sv
// Dual-channel serial output framer with its AXI4-Lite register slave.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module asof_framer (
  input  wire logic                         CLOCK,
  input  wire logic                         SYS_RST,
  input  wire logic [asof_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
  input  wire logic                         S_AXI_AWVALID,
  output logic                              S_AXI_AWREADY,
  input  wire logic [asof_pkg::DATA_W-1:0]  S_AXI_WDATA,
  input  wire logic [3:0]                   S_AXI_WSTRB,
  input  wire logic                         S_AXI_WVALID,
  output logic                              S_AXI_WREADY,
  output logic [1:0]                        S_AXI_BRESP,
  output logic                              S_AXI_BVALID,
  input  wire logic                         S_AXI_BREADY,
  input  wire logic [asof_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
  input  wire logic                         S_AXI_ARVALID,
  output logic                              S_AXI_ARREADY,
  output logic [asof_pkg::DATA_W-1:0]       S_AXI_RDATA,
  output logic [1:0]                        S_AXI_RRESP,
  output logic                              S_AXI_RVALID,
  input  wire logic                         S_AXI_RREADY,
  input  wire asof_pkg::asof_sample_t       SAMPLE_IN,
  output logic                              SAMPLE_TAKEN,
  input  wire logic                         POWER_DOWN_PIN,
  output logic [3:0]                        LANE_OUT,
  output logic [3:0]                        LANE_OE,
  output logic                              BIT_CLOCK_OUT,
  output logic                              BIT_CLOCK_OE,
  output logic                              WORD_FRAME_CLOCK_OUT,
  output logic                              WORD_FRAME_CLOCK_OE,
  output logic                              REFERENCE_ON
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  asof_pkg::asof_ctrl_t         ctrl_ff;
  asof_pkg::asof_ctrl_t         nxt_ctrl;
  logic                         aw_got_ff;
  logic                         w_got_ff;
  logic [asof_pkg::ADDR_W-1:0]  aw_addr_ff;
  logic [asof_pkg::DATA_W-1:0]  w_data_ff;
  logic [3:0]                   w_strb_ff;
  logic                         bvalid_ff;
  logic [1:0]                   bresp_ff;
  logic                         rvalid_ff;
  logic [1:0]                   rresp_ff;
  logic [asof_pkg::DATA_W-1:0]  rdata_ff;
  logic [asof_pkg::DATA_W-1:0]  rd_word;
  logic                         rd_hit;
  logic                         wr_fire;
  logic                         wr_hit;
  logic [31:0]                  word_cnt_ff;
  logic                         pdn_act;
  logic                         stby_act;
  logic                         run;
  logic                         tick;
  logic                         rate_over;
  logic                         started_ff;
  logic [1:0]                   sub_ff;
  logic [3:0]                   slot_ff;
  logic                         w12_ff;
  logic                         one_ff;
  logic                         load;
  logic                         slot_edge;
  logic [1:0]                   nxt_sub;
  logic [3:0]                   nxt_slot;
  logic [3:0]                   last_slot;
  logic [3:0]                   half_slot;
  logic                         use_w12;
  logic                         use_one;
  logic [2:0]                   bclk_pos;
  logic [3:0]                   phase_pos;
  logic                         bclk_ff;
  logic                         frame_ff;
  logic                         oe_ff;
  logic [3:0]                   lane_ff;

  // ----------------------------------------------------------------
  // Word shaping
  // ----------------------------------------------------------------
  // Bit i of the result is the i-th bit placed on the wire.
  function automatic logic [15:0] shape(input logic [13:0] d,
                                        input logic        w12,
                                        input logic        lsbf,
                                        input logic        offb);
    logic [13:0] enc;
    logic [15:0] seq;
    enc = offb ? {~d[13], d[12:0]} : d;
    seq = '0;
    for (int i = 0; i < asof_pkg::DATA_BITS; i++) begin
      if (w12) begin
        if (i < asof_pkg::WORD12_BITS) begin
          seq[i] = lsbf ? enc[i + asof_pkg::DATA_BITS - asof_pkg::WORD12_BITS]
                        : enc[asof_pkg::DATA_BITS - 1 - i];
        end
      end else begin
        seq[i] = lsbf ? enc[i] : enc[asof_pkg::DATA_BITS - 1 - i];
      end
    end
    return seq;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are latched separately, so either may arrive first.
  assign S_AXI_AWREADY = !aw_got_ff && !bvalid_ff;
  assign S_AXI_WREADY  = !w_got_ff && !bvalid_ff;
  assign wr_fire       = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_hit        = (aw_addr_ff == asof_pkg::REG_CTRL) ||
                         (aw_addr_ff == asof_pkg::REG_STATUS) ||
                         (aw_addr_ff == asof_pkg::REG_COUNT);

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_ff  <= 1'b1;
      aw_addr_ff <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_got_ff  <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      w_got_ff  <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_ff  <= 1'b1;
      w_data_ff <= S_AXI_WDATA;
      w_strb_ff <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_got_ff  <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= asof_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? asof_pkg::RESP_OKAY : asof_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP  = bresp_ff;

  // Only the control register is writable; byte strobes gate each byte.
  always_comb begin
    logic [asof_pkg::DATA_W-1:0] cur;
    cur = asof_pkg::DATA_W'(ctrl_ff);
    for (int b = 0; b < 4; b++) begin
      if (w_strb_ff[b]) begin
        cur[b*8 +: 8] = w_data_ff[b*8 +: 8];
      end
    end
    nxt_ctrl = asof_pkg::asof_ctrl_t'(cur[asof_pkg::CTRL_W-1:0]);
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_ff <= asof_pkg::CTRL_RST;
    end else if (wr_fire && aw_addr_ff == asof_pkg::REG_CTRL) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign S_AXI_ARREADY = !rvalid_ff;

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (S_AXI_ARADDR)
      asof_pkg::REG_CTRL:   rd_word = asof_pkg::DATA_W'(ctrl_ff);
      asof_pkg::REG_STATUS: rd_word = {28'h000_0000, POWER_DOWN_PIN, rate_over,
                                       stby_act, pdn_act};
      asof_pkg::REG_COUNT:  rd_word = word_cnt_ff;
      default:              rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= asof_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_hit ? asof_pkg::RESP_OKAY : asof_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA  = rdata_ff;
  assign S_AXI_RRESP  = rresp_ff;

  // ----------------------------------------------------------------
  // Power modes and rate
  // ----------------------------------------------------------------
  assign pdn_act      = ctrl_ff.power_down || POWER_DOWN_PIN;
  assign stby_act     = ctrl_ff.standby && !pdn_act;
  assign run          = !pdn_act && !stby_act;
  assign REFERENCE_ON = !pdn_act;
  // A divider below MIN_DIV, the fastest legal setting, flags a lane overrun.
  assign rate_over    = ({1'b0, ctrl_ff.div_m1} + 4'h1) < 4'(asof_pkg::MIN_DIV);

  asof_tick_div u_div (
    .clk    (CLOCK),
    .rst    (SYS_RST),
    .run    (run),
    .div_m1 (ctrl_ff.div_m1),
    .tick   (tick)
  );

  // ----------------------------------------------------------------
  // Slot sequencing
  // ----------------------------------------------------------------
  // Word length and lane mode are latched per word so a change never splits one.
  assign load      = tick && (!started_ff || (sub_ff == asof_pkg::SUB_LAST &&
                                              slot_ff == last_slot));
  assign slot_edge = tick && (!started_ff || sub_ff == asof_pkg::SUB_LAST);
  assign use_w12   = load ? ctrl_ff.word12 : w12_ff;
  assign use_one   = load ? ctrl_ff.one_lane : one_ff;
  assign SAMPLE_TAKEN = load;

  always_comb begin
    unique case ({one_ff, w12_ff})
      2'b00:   begin last_slot = asof_pkg::LAST_16_2L; half_slot = asof_pkg::HALF_16_2L; end
      2'b01:   begin last_slot = asof_pkg::LAST_12_2L; half_slot = asof_pkg::HALF_12_2L; end
      2'b10:   begin last_slot = asof_pkg::LAST_16_1L; half_slot = asof_pkg::HALF_16_1L; end
      default: begin last_slot = asof_pkg::LAST_12_1L; half_slot = asof_pkg::HALF_12_1L; end
    endcase
  end

  always_comb begin
    nxt_sub  = sub_ff;
    nxt_slot = slot_ff;
    if (load) begin
      nxt_sub  = 2'h0;
      nxt_slot = 4'h0;
    end else if (slot_edge) begin
      nxt_sub  = 2'h0;
      nxt_slot = slot_ff + 4'h1;
    end else if (tick) begin
      nxt_sub  = sub_ff + 2'h1;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      started_ff <= 1'b0;
      sub_ff     <= 2'h0;
      slot_ff    <= 4'h0;
      w12_ff     <= 1'b0;
      one_ff     <= 1'b0;
    end else if (!run) begin
      started_ff <= 1'b0;
      sub_ff     <= 2'h0;
      slot_ff    <= 4'h0;
    end else begin
      sub_ff  <= nxt_sub;
      slot_ff <= nxt_slot;
      if (load) begin
        started_ff <= 1'b1;
        w12_ff     <= ctrl_ff.word12;
        one_ff     <= ctrl_ff.one_lane;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      word_cnt_ff <= 32'h0000_0000;
    end else if (load) begin
      word_cnt_ff <= word_cnt_ff + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Clocks out
  // ----------------------------------------------------------------
  // One bit clock period spans two slots, so it runs at four per 16-bit word in two-lane mode and eight in one-lane mode.
  assign bclk_pos  = nxt_slot[0] ? (3'(asof_pkg::TICKS_PER_SLOT) + {1'b0, nxt_sub})
                                 : {1'b0, nxt_sub};
  assign phase_pos = 4'((5'({2'b00, bclk_pos}) + 5'(2 * asof_pkg::PHASE_STEPS) -
                        5'({2'b00, ctrl_ff.phase})) % 5'(asof_pkg::PHASE_STEPS));

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bclk_ff  <= 1'b0;
      frame_ff <= 1'b0;
      oe_ff    <= 1'b0;
    end else begin
      oe_ff <= run;
      if (!run) begin
        bclk_ff  <= 1'b0;
        frame_ff <= 1'b0;
      end else if (tick) begin
        bclk_ff <= phase_pos >= 4'(asof_pkg::TICKS_PER_SLOT);
        if (slot_edge) begin
          frame_ff <= nxt_slot < half_slot;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel serializers
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < asof_pkg::CHANNELS; ch++) begin : g_chan
    logic [15:0] seq_ff;
    logic [15:0] seq_use;
    logic [4:0]  idx;
    assign seq_use = load ? shape(SAMPLE_IN.chan[ch], use_w12, ctrl_ff.lsb_first,
                                  ctrl_ff.offset_binary) : seq_ff;
    assign idx     = use_one ? {1'b0, nxt_slot} : {nxt_slot, 1'b0};

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
        seq_ff                            <= 16'h0000;
        lane_ff[ch*asof_pkg::LANES +: 2]  <= 2'b00;
      end else if (!run) begin
        lane_ff[ch*asof_pkg::LANES +: 2]  <= 2'b00;
      end else if (slot_edge) begin
        if (load) begin
          seq_ff <= seq_use;
        end
        if (use_one) begin
          lane_ff[ch*asof_pkg::LANES +: 2] <= {1'b0, seq_use[idx[3:0]]};
        end else begin
          lane_ff[ch*asof_pkg::LANES +: 2] <= {seq_use[idx[3:0] + 4'h1],
                                               seq_use[idx[3:0]]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Drivers release together in power-down and standby, never piecemeal.
  assign LANE_OUT             = lane_ff;
  assign LANE_OE              = {4{oe_ff}};
  assign BIT_CLOCK_OUT        = bclk_ff;
  assign BIT_CLOCK_OE         = oe_ff;
  assign WORD_FRAME_CLOCK_OUT = frame_ff;
  assign WORD_FRAME_CLOCK_OE  = oe_ff;

endmodule // asof_framer

// File: asof_pkg.sv
// Shared constants and carrier types for the serial output framer.
package asof_pkg;

  // ----------------------------------------------------------------
  // Clocking and lane rate
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ         = 50_000_000;
  localparam longint unsigned MAX_LANE_BPS   = 1_000_000_000;
  // One lane bit is three ticks long, so the bit clock phase moves in sixths.
  localparam int unsigned     TICKS_PER_SLOT = 3;
  localparam int unsigned     TICKS_PER_BCLK = 2 * TICKS_PER_SLOT;
  localparam int unsigned     PHASE_STEPS    = 6;
  localparam longint unsigned MIN_DIV        =
    (CLK_HZ + TICKS_PER_SLOT * MAX_LANE_BPS - 1) / (TICKS_PER_SLOT * MAX_LANE_BPS);
  localparam logic [1:0]      SUB_LAST       = 2'h2;
  localparam logic [2:0]      PHASE_180      = 3'h3;

  // ----------------------------------------------------------------
  // Word shaping
  // ----------------------------------------------------------------
  localparam int unsigned DATA_BITS   = 14;
  localparam int unsigned WORD16_BITS = 16;
  localparam int unsigned WORD12_BITS = 12;
  localparam int unsigned CHANNELS    = 2;
  localparam int unsigned LANES       = 2;
  // Last slot index and first low-frame slot per word length and lane mode.
  localparam logic [3:0]  LAST_16_2L  = 4'h7;
  localparam logic [3:0]  LAST_12_2L  = 4'h5;
  localparam logic [3:0]  LAST_16_1L  = 4'hF;
  localparam logic [3:0]  LAST_12_1L  = 4'hB;
  localparam logic [3:0]  HALF_16_2L  = 4'h4;
  localparam logic [3:0]  HALF_12_2L  = 4'h3;
  localparam logic [3:0]  HALF_16_1L  = 4'h8;
  localparam logic [3:0]  HALF_12_1L  = 4'h6;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_COUNT   = 8'h08;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int unsigned CTRL_W      = 12;

  typedef struct packed {
    logic       standby;
    logic       power_down;
    logic       one_lane;
    logic       offset_binary;
    logic       lsb_first;
    logic       word12;
    logic [2:0] phase;
    logic [2:0] div_m1;
  } asof_ctrl_t;

  localparam asof_ctrl_t CTRL_RST = '{standby: 1'b0, power_down: 1'b0, one_lane: 1'b0,
                                      offset_binary: 1'b0, lsb_first: 1'b0, word12: 1'b0,
                                      phase: PHASE_180, div_m1: 3'h0};

  typedef struct packed {
    logic [CHANNELS-1:0][DATA_BITS-1:0] chan;
  } asof_sample_t;

endpackage

// File: asof_tick_div.sv
// Programmable divider that turns the system clock into the tick enable.
module asof_tick_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] div_m1,
  output logic            tick
);

  logic [2:0] cnt_ff;

  // Divides by div_m1 + 1, so one to eight clocks per tick.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 3'h0;
    end else if (!run || cnt_ff >= div_m1) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end

  assign tick = run && (cnt_ff >= div_m1);

endmodule // asof_tick_div

// File: asof_framer_sva.sv
// Pin level checks of the serial output framer.
module asof_framer_sva (
  input wire logic       CLOCK,
  input wire logic       SYS_RST,
  input wire logic       SAMPLE_TAKEN,
  input wire logic       POWER_DOWN_PIN,
  input wire logic [3:0] LANE_OUT,
  input wire logic [3:0] LANE_OE,
  input wire logic       BIT_CLOCK_OUT,
  input wire logic       BIT_CLOCK_OE,
  input wire logic       WORD_FRAME_CLOCK_OUT,
  input wire logic       WORD_FRAME_CLOCK_OE,
  input wire logic       REFERENCE_ON
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // The bit clock checks assume the default phase, which the bench keeps.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence pin_held;
    POWER_DOWN_PIN [*3];
  endsequence
  sequence word_start;
    SAMPLE_TAKEN && LANE_OE[0] && !POWER_DOWN_PIN;
  endsequence
  sequence slot_move;
    LANE_OE[0] && $past(LANE_OE[0]) && LANE_OUT != $past(LANE_OUT);
  endsequence
  pin_hiz_a: assert property (pin_held |-> LANE_OE == 4'h0 && !BIT_CLOCK_OE)
    else $error("drivers still on while the pin is held high");
  pin_ref_a: assert property (pin_held |-> !REFERENCE_ON)
    else $error("reference still on while the pin is held high");
  oe_group_a: assert property (LANE_OE == {4{BIT_CLOCK_OE}} && WORD_FRAME_CLOCK_OE == BIT_CLOCK_OE)
    else $error("output enables disagree");
  ref_gate_a: assert property (!REFERENCE_ON |=> !BIT_CLOCK_OE && !WORD_FRAME_CLOCK_OE)
    else $error("drivers on with the reference off");
  frame_first_a: assert property (word_start |=> $rose(WORD_FRAME_CLOCK_OUT))
    else $error("frame clock did not rise with the first bit");
  frame_cause_a: assert property ($rose(WORD_FRAME_CLOCK_OUT) |-> $past(SAMPLE_TAKEN))
    else $error("frame clock rose without a word start");
  bclk_frame_a: assert property ($rose(WORD_FRAME_CLOCK_OUT) |-> BIT_CLOCK_OUT)
    else $error("bit clock low at word start");
  bclk_slot_a: assert property (slot_move |-> BIT_CLOCK_OUT != $past(BIT_CLOCK_OUT))
    else $error("lane change without a bit clock edge");
endmodule // asof_framer_sva

bind asof_framer asof_framer_sva u_sva (.CLOCK, .SYS_RST, .SAMPLE_TAKEN, .POWER_DOWN_PIN,
  .LANE_OUT, .LANE_OE, .BIT_CLOCK_OUT, .BIT_CLOCK_OE, .WORD_FRAME_CLOCK_OUT,
  .WORD_FRAME_CLOCK_OE, .REFERENCE_ON);

// File: asof_rx_model.sv
// Receiver model that rebuilds each word from the lanes at every bit clock edge.
module asof_rx_model (
  input  wire logic       clk,
  input  wire logic [3:0] lanes,
  input  wire logic       bclk,
  input  wire logic       frame,
  input  wire logic       one_lane,
  output int              word0,
  output int              word1,
  output int              nbits,
  output logic            done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bclk_q  = 1'h0;
  logic frame_q = 1'h0;
  int   a0      = 0;
  int   a1      = 0;
  int   n       = 0;
  initial done = 1'h0;
  // Sampling one clock after the edge is safe because lanes hold a whole slot.
  always @(posedge clk) begin
    done <= 1'h0;
    if (frame && !frame_q) begin
      word0 <= a0;
      word1 <= a1;
      nbits <= n;
      done  <= 1'h1;
      a0 = 0;
      a1 = 0;
      n  = 0;
    end
    if (bclk != bclk_q) begin
      a0 = (a0 << 1) | lanes[0];
      a1 = (a1 << 1) | lanes[2];
      n  = n + 1;
      if (!one_lane) begin
        a0 = (a0 << 1) | lanes[1];
        a1 = (a1 << 1) | lanes[3];
        n  = n + 1;
      end
    end
    bclk_q  = bclk;
    frame_q = frame;
  end
endmodule // asof_rx_model

// File: testbench.sv
// Self-checking bench of the serial output framer.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic                   clock = 1'h0;
  logic                   sys_rst = 1'h1;
  logic [7:0]             awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]            wdata = 32'h0000_0000, rdata;
  logic                   awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic                   rready = 1'h0, pin = 1'h0, armed = 1'h0, arm_req = 1'h0, done;
  logic                   awready, wready, bvalid, arready, rvalid, taken;
  logic                   bclk, bclk_oe, frame, frame_oe, ref_on;
  logic [1:0]             bresp, rresp;
  logic [3:0]             lane, lane_oe;
  logic [11:0]            ctrl = 12'h018;
  logic [13:0]            tab [3] = '{14'h2000, 14'h1FFF, 14'h0000};
  logic [11:0]            modes [8] = '{12'h018, 12'h058, 12'h098, 12'h118, 12'h218, 12'h2D8,
                                        12'h01F, 12'h15B};
  asof_pkg::asof_sample_t sample = '0;
  int                     n_errors = 0, checks_done = 0, w0, w1, nb, drop = 0, idx = 0;
  int                     cnt = 0, bits, q0 [$], q1 [$], n_words = 0;
  always #10 clock = ~clock;
  asof_framer DUT (.CLOCK(clock), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .SAMPLE_IN(sample), .SAMPLE_TAKEN(taken), .POWER_DOWN_PIN(pin),
    .LANE_OUT(lane), .LANE_OE(lane_oe), .BIT_CLOCK_OUT(bclk), .BIT_CLOCK_OE(bclk_oe),
    .WORD_FRAME_CLOCK_OUT(frame), .WORD_FRAME_CLOCK_OE(frame_oe), .REFERENCE_ON(ref_on));
  // A released line shows the inverse of its cleared output, so it reads high.
  asof_rx_model u_rx (.clk(clock), .lanes(lane ^ ~lane_oe), .bclk(bclk ^ ~bclk_oe),
    .frame(frame ^ ~frame_oe), .one_lane(ctrl[9]), .word0(w0), .word1(w1), .nbits(nb),
    .done(done));
  // ----------------------------------------------------------------
  // Tasks and reference model
  // ----------------------------------------------------------------
  task automatic check_sig(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (awvalid && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    bready <= 1'h1;
    @(posedge clock iff bvalid === 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    @(posedge clock iff arready === 1'h1);
    arvalid <= 1'h0;
    rready <= 1'h1;
    @(posedge clock iff rvalid === 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  function automatic int rev(input int v, input int w);
    int r;
    r = 0;
    for (int i = 0; i < w; i++) r = (r << 1) | ((v >> i) & 1);
    return r;
  endfunction
  function automatic int expect_word(input int d);
    if (ctrl[8]) d = d ^ 'h2000;
    if (ctrl[6]) return ctrl[7] ? rev(d >> 2, 12) : d >> 2;
    return (ctrl[7] ? rev(d, 14) : d) << 2;
  endfunction
  always @(posedge clock) begin
    bits = ctrl[6] ? 12 : 16;
    if (taken === 1'h1) begin
      if (!sys_rst) n_words++;
      if (armed) check_sig("word spacing", 3 * bits / (ctrl[9] ? 1 : 2) * (ctrl[2:0] + 1), cnt);
      if (arm_req) begin
        armed = 1'h1;
        drop = 1;
        arm_req = 1'h0;
        idx = 0;
      end
      if (armed) q0.push_back(expect_word(sample.chan[0]));
      if (armed) q1.push_back(expect_word(sample.chan[1]));
      sample.chan[0] <= (idx < 3) ? tab[idx] : 14'($urandom);
      sample.chan[1] <= 14'($urandom);
      idx++;
      cnt = 1;
    end else cnt++;
    if (done === 1'h1 && armed) begin
      if (drop > 0) drop--;
      else if (q0.size() > 0) begin
        check_sig("lane word ch0", q0.pop_front(), w0);
        check_sig("lane word ch1", q1.pop_front(), w1);
        check_sig("bits per word", bits, nb);
      end
    end
  end
  task automatic run_mode(input logic [11:0] c);
    logic [31:0] d;
    logic [1:0]  r;
    armed = 1'h0;
    q0.delete();
    q1.delete();
    axi_write(8'h00, {20'h0_0000, c}, r);
    check_sig("write resp", asof_pkg::RESP_OKAY, r);
    ctrl = c;
    axi_read(8'h00, d, r);
    check_sig("ctrl readback", {20'h0_0000, c}, d);
    repeat (2) @(posedge clock iff taken === 1'h1);
    arm_req = 1'h1;
    repeat (6) @(posedge clock iff taken === 1'h1);
    $display("test ctrl %h done", c);
  endtask
  task automatic power_test();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(8'h00, d, r);
    check_sig("ctrl reset", 32'h0000_0018, d);
    axi_read(8'h0C, d, r);
    check_sig("unmapped resp", asof_pkg::RESP_SLVERR, r);
    axi_write(8'h0C, 32'h0000_0000, r);
    check_sig("unmapped write", asof_pkg::RESP_SLVERR, r);
    pin <= 1'h1;
    repeat (4) @(posedge clock);
    check_sig("oe pin down", 32'h0000_0000, {lane_oe, bclk_oe, frame_oe, ref_on});
    axi_read(8'h04, d, r);
    check_sig("status pin", 32'h0000_0009, d);
    pin <= 1'h0;
    repeat (4) @(posedge clock);
    check_sig("oe pin up", 32'h0000_007F, {lane_oe, bclk_oe, frame_oe, ref_on});
    axi_write(8'h00, 32'h0000_0818, r);
    repeat (4) @(posedge clock);
    check_sig("oe standby", 32'h0000_0001, {lane_oe, bclk_oe, frame_oe, ref_on});
    axi_read(8'h04, d, r);
    check_sig("status standby", 32'h0000_0002, d);
    axi_write(8'h00, 32'h0000_0418, r);
    repeat (4) @(posedge clock);
    check_sig("oe reg down", 32'h0000_0000, {lane_oe, bclk_oe, frame_oe, ref_on});
    axi_read(8'h08, d, r);
    check_sig("word count", n_words, d);
    axi_write(8'h00, 32'h0000_0018, r);
    $display("power test done");
  endtask
  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(68));
    repeat (16) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    power_test();
    foreach (modes[i]) run_mode(modes[i]);
    complete_run();
  end
  initial begin
    #1_000_000;
    n_errors++;
    complete_run();
  end
endmodule // testbench
